// *** inc/sef_pkg.sv ***
`default_nettype none

package sef_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 40;
   // self-timed write cycle length; a plain default
   localparam int WRITE_TIME_NS = 5000000;
   // least time, so round up
   localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ----------------------------------------------------------------
   // select byte and address layout
   // ----------------------------------------------------------------
   localparam int SEL_TYPE_MSB = 7;
   localparam int SEL_TYPE_LSB = 4;
   localparam int SEL_CS_LSB = 1;
   localparam int SEL_RW_BIT = 0;
   localparam int CS_BITS = 3;
   localparam int ADDR_W = 11;
   localparam int BYTE_ADDR_W = 8;
   localparam int PAGE_BITS = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_OUT_BIT = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;

   // ----------------------------------------------------------------
   // link engine states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_SEL,
      ST_SEL_ACK,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RACK,
      ST_RWAIT
   } sef_state_t;

endpackage

`default_nettype wire

// *** rtl/sef_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// two-flop level synchroniser, no reset so it settles after two edges
// ------------------------------------------------------------------
module sef_sync2 #(
   parameter int WIDTH = 1
) (
   // destination clock
   input wire logic clk,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      meta_q <= async_in;
      sync_out <= meta_q;
   end

endmodule

`default_nettype wire

// *** rtl/sef_front_end.sv ***
// Function
// - sample SDA on rising SCL
// - START is SDA fall with SCL high
// - ignore bus until START, except while programming
// - STOP is SDA rise with SCL high
// - read standby only on STOP after NoAck
// - STOP ending write starts write cycle
// - receiver pulls SDA low in ninth clock
// - SDA only pulled low or released
// - select byte: type, chip select, rw
// - respond on type and strap match
// - larger variants use select bits as address
// - rw one reads, zero writes
// - ack match, else release until START
// - write: ack select, ack address, await data
// - protect high: no data ack, no change
// - protect high START..address end inhibits write
// - floating protect input reads as low (no pull in the code; the pad must pull it low)
// - reads ignore protect; sequential reads continue
// - page write increments low four bits
// - only STOP right after data ack triggers
// - during write cycle ignore SDA, no ack
// - random read: dummy write, repeated START
`timescale 1ns/1ps
`default_nettype none

module sef_front_end
   import sef_pkg::*;
#(
   // arbitrary type identifier value
   parameter logic [3:0] DEVICE_TYPE = 4'h6,
   // select bits used as address bits, 0 to 3
   parameter int HI_ADDR_BITS = 0,
   parameter int WRITE_CYCLE_COUNT = WRITE_CYCLES
) (
   // system clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bus sampling clock
   input wire logic link_clk,
   // serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // straps and protect
   input wire logic chip_select_strap_0,
   input wire logic chip_select_strap_1,
   input wire logic chip_select_strap_2,
   input wire logic write_protect_input,
   // memory side, system clock
   output logic mem_wr_en,
   output logic [ADDR_W-1:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   output logic mem_rd_en,
   output logic [ADDR_W-1:0] mem_rd_addr,
   input wire logic [7:0] mem_rdata,
   output logic write_cycle_start,
   output logic write_busy
);

   // ----------------------------------------------------------------
   // select decode
   // ----------------------------------------------------------------
   function automatic logic sel_match(input logic [7:0] sel, input logic [2:0] cs);
      logic ok;
      ok = (sel[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEVICE_TYPE);
      for (int i = 0; i < CS_BITS; i++) begin
         if (i >= HI_ADDR_BITS && sel[SEL_CS_LSB+i] != cs[i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'((1 << (BYTE_ADDR_W + HI_ADDR_BITS)) - 1);

   // ----------------------------------------------------------------
   // link domain synchronisers
   // ----------------------------------------------------------------
   logic busy_q, rd_ack_tgl_q;
   logic [7:0] lk_raw, lk_s;
   logic scl_s, sda_s, wp_s, busy_s, ack_tgl_s, link_rst_n;
   logic [2:0] cs_s;

   assign lk_raw = {rst_n, rd_ack_tgl_q, busy_q, write_protect_input,
                    chip_select_strap_2, chip_select_strap_1, chip_select_strap_0, scl_i};

   sef_sync2 #(.WIDTH(8)) u_lk_sync (
      .clk(link_clk),
      .async_in(lk_raw),
      .sync_out(lk_s)
   );

   // sda gets its own pair so the edge detector reads only the second flop
   sef_sync2 #(.WIDTH(1)) u_sda_sync (
      .clk(link_clk),
      .async_in(sda_i),
      .sync_out(sda_s)
   );

   assign scl_s = lk_s[0];
   assign cs_s = lk_s[3:1];
   // floating protect input must be pulled low at the pad
   assign wp_s = lk_s[4];
   assign busy_s = lk_s[5];
   assign ack_tgl_s = lk_s[6];
   assign link_rst_n = lk_s[7];

   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   logic scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // data is taken only on rising SCL, so master changes while low are harmless
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ----------------------------------------------------------------
   // link engine
   // ----------------------------------------------------------------
   sef_state_t st_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic rw_q, inhibit_q, after_ack_q, data_any_q, wait_q, link_busy, trig;
   logic [ADDR_W-1:0] addr_q, rd_addr_q, wr_addr_q;
   logic [7:0] wr_data_q, rd_data_q;
   logic wr_tgl_q, commit_tgl_q, rd_req_tgl_q, rd_ready;
   logic byte_done;
   logic [7:0] next_out;

   assign link_busy = wait_q | busy_s;
   assign byte_done = scl_fall && bit_cnt_q == BITS_PER_BYTE;
   assign rd_ready = (ack_tgl_s == rd_req_tgl_q);
   // a late read answer leaves the bus released rather than sending stale data
   assign next_out = rd_ready ? rd_data_q : IDLE_BYTE;
   assign trig = stop_ev && !link_busy && st_q == ST_WDATA && after_ack_q
                 && data_any_q && !inhibit_q;

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         st_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe_n <= 1'b1;
         addr_q <= ADDR_RESET;
      end else if (link_busy) begin
         st_q <= ST_IDLE;
         sda_oe_n <= 1'b1;
      end else if (start_ev) begin
         st_q <= ST_SEL;
         bit_cnt_q <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (stop_ev) begin
         // a STOP mid read without NoAck does not force standby
         if (st_q != ST_RDATA && st_q != ST_RACK) begin
            st_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end
      end else begin
         case (st_q)
            ST_SEL, ST_ADDR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_q <= 4'h0;
                  if (st_q == ST_SEL) begin
                     if (sel_match(shift_q, cs_s)) begin
                        st_q <= ST_SEL_ACK;
                        sda_oe_n <= 1'b0;
                        rw_q <= shift_q[SEL_RW_BIT];
                        for (int i = 0; i < HI_ADDR_BITS; i++) begin
                           addr_q[BYTE_ADDR_W+i] <= shift_q[SEL_CS_LSB+i];
                        end
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end else if (st_q == ST_ADDR) begin
                     addr_q[BYTE_ADDR_W-1:0] <= shift_q;
                     st_q <= ST_ADDR_ACK;
                     sda_oe_n <= 1'b0;
                  end else begin
                     st_q <= ST_WDATA_ACK;
                     sda_oe_n <= inhibit_q;
                     if (!inhibit_q) begin
                        addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + 4'h1;
                     end
                  end
               end
            end
            ST_SEL_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (rw_q) begin
                     // protect input plays no part in reads
                     st_q <= ST_RDATA;
                     shift_q <= next_out;
                     sda_oe_n <= next_out[7];
                     addr_q <= (addr_q + 11'h001) & ADDR_MASK;
                  end else begin
                     st_q <= ST_ADDR;
                     sda_oe_n <= 1'b1;
                  end
               end
            end
            ST_ADDR_ACK, ST_WDATA_ACK: begin
               if (scl_fall) begin
                  st_q <= ST_WDATA;
                  sda_oe_n <= 1'b1;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt_q == LAST_OUT_BIT) begin
                     st_q <= ST_RACK;
                     sda_oe_n <= 1'b1;
                     bit_cnt_q <= 4'h0;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b1};
                     sda_oe_n <= shift_q[6];
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise && sda_s) begin
                  st_q <= ST_RWAIT;
               end else if (scl_fall && bit_cnt_q != 4'h0) begin
                  st_q <= ST_RDATA;
                  bit_cnt_q <= 4'h0;
                  shift_q <= next_out;
                  sda_oe_n <= next_out[7];
                  addr_q <= (addr_q + 11'h001) & ADDR_MASK;
               end else if (scl_rise) begin
                  bit_cnt_q <= 4'h1;
               end
            end
            ST_RWAIT, ST_IDLE: begin
               sda_oe_n <= 1'b1;
            end
            default: begin
               st_q <= ST_IDLE;
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // only pulled low or released
   assign sda_o = 1'b0;

   // write protect seen anywhere from START to the end of the address byte
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         inhibit_q <= 1'b0;
      end else if (start_ev) begin
         inhibit_q <= wp_s;
      end else if (st_q == ST_SEL || st_q == ST_SEL_ACK || st_q == ST_ADDR
                   || st_q == ST_ADDR_ACK) begin
         inhibit_q <= inhibit_q | wp_s;
      end
   end

   // marks the tenth bit time after a data ack; a STOP needs SCL high,
   // so the flag lives through the next rising SCL until the next falling one
   always_ff @(posedge link_clk) begin
      if (!link_rst_n || start_ev) begin
         after_ack_q <= 1'b0;
         data_any_q <= 1'b0;
      end else begin
         if ((st_q == ST_ADDR_ACK || st_q == ST_WDATA_ACK) && scl_fall) begin
            after_ack_q <= (st_q == ST_WDATA_ACK);
            data_any_q <= data_any_q | (st_q == ST_WDATA_ACK);
         end else if (scl_fall) begin
            after_ack_q <= 1'b0;
         end
      end
   end

   // data byte and commit events toward the system domain
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         wr_tgl_q <= 1'b0;
         wr_addr_q <= ADDR_RESET;
         wr_data_q <= 8'h00;
         commit_tgl_q <= 1'b0;
      end else begin
         if (st_q == ST_WDATA && byte_done && !inhibit_q && !link_busy
             && !start_ev && !stop_ev) begin
            wr_tgl_q <= ~wr_tgl_q;
            wr_addr_q <= addr_q;
            wr_data_q <= shift_q;
         end
         if (trig) begin
            commit_tgl_q <= ~commit_tgl_q;
         end
      end
   end

   // holds off the bus until the system domain reports busy
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         wait_q <= 1'b0;
      end else if (trig) begin
         wait_q <= 1'b1;
      end else if (busy_s) begin
         wait_q <= 1'b0;
      end
   end

   // read requests ask for the byte at the current counter
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         rd_req_tgl_q <= 1'b0;
         rd_addr_q <= ADDR_RESET;
      end else if (!link_busy && !start_ev && !stop_ev) begin
         if (st_q == ST_SEL_ACK && scl_rise && rw_q) begin
            rd_req_tgl_q <= ~rd_req_tgl_q;
            rd_addr_q <= addr_q;
         end else if (st_q == ST_RACK && scl_rise && !sda_s) begin
            rd_req_tgl_q <= ~rd_req_tgl_q;
            rd_addr_q <= addr_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // system domain
   // ----------------------------------------------------------------
   logic [2:0] sy_s;
   logic wr_tgl_p_q, commit_p_q, rd_req_p_q;
   logic [31:0] timer_q;

   sef_sync2 #(.WIDTH(3)) u_sy_sync (
      .clk(clock),
      .async_in({rd_req_tgl_q, commit_tgl_q, wr_tgl_q}),
      .sync_out(sy_s)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_tgl_p_q <= 1'b0;
         commit_p_q <= 1'b0;
         rd_req_p_q <= 1'b0;
      end else begin
         wr_tgl_p_q <= sy_s[0];
         commit_p_q <= sy_s[1];
         rd_req_p_q <= sy_s[2];
      end
   end

   // link holding registers are stable for many cycles after a toggle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mem_wr_en <= 1'b0;
         mem_wr_addr <= ADDR_RESET;
         mem_wr_data <= 8'h00;
      end else begin
         mem_wr_en <= sy_s[0] ^ wr_tgl_p_q;
         if (sy_s[0] ^ wr_tgl_p_q) begin
            mem_wr_addr <= wr_addr_q;
            mem_wr_data <= wr_data_q;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         write_cycle_start <= 1'b0;
         busy_q <= 1'b0;
         timer_q <= 32'h0;
      end else begin
         write_cycle_start <= sy_s[1] ^ commit_p_q;
         if (sy_s[1] ^ commit_p_q) begin
            busy_q <= 1'b1;
            timer_q <= 32'(WRITE_CYCLE_COUNT);
         end else if (busy_q) begin
            if (timer_q <= 32'h1) begin
               busy_q <= 1'b0;
            end
            timer_q <= timer_q - 32'h1;
         end
      end
   end

   assign write_busy = busy_q;

   // memory read assumed to answer one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mem_rd_en <= 1'b0;
         mem_rd_addr <= ADDR_RESET;
         rd_data_q <= IDLE_BYTE;
         rd_ack_tgl_q <= 1'b0;
      end else begin
         mem_rd_en <= sy_s[2] ^ rd_req_p_q;
         if (sy_s[2] ^ rd_req_p_q) begin
            mem_rd_addr <= rd_addr_q;
         end
         if (mem_rd_en) begin
            rd_data_q <= mem_rdata;
            rd_ack_tgl_q <= ~rd_ack_tgl_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sel_reject_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (st_q == ST_SEL && byte_done && !link_busy && !start_ev && !stop_ev
       && !sel_match(shift_q, cs_s)) |=> (st_q == ST_IDLE && sda_oe_n))
      else $error("mismatched select not rejected");

   drive_when_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      !sda_oe_n |-> (st_q inside {ST_SEL_ACK, ST_ADDR_ACK, ST_WDATA_ACK, ST_RDATA}))
      else $error("sda pulled low outside ack or read data");

   start_seen_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (start_ev && !link_busy) |=> (st_q == ST_SEL && bit_cnt_q == 4'h0))
      else $error("start not taken");

   busy_quiet_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      link_busy |=> (sda_oe_n && st_q == ST_IDLE))
      else $error("bus active during write cycle");

   wp_nack_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (st_q == ST_WDATA_ACK && inhibit_q) |-> sda_oe_n)
      else $error("protected data byte acknowledged");

   commit_when_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      $changed(commit_tgl_q) |-> ($past(st_q) == ST_WDATA && $past(after_ack_q)
                                  && $past(stop_ev))) 
      else $error("write cycle from wrong stop");

   page_wrap_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (st_q == ST_WDATA_ACK && $past(st_q) == ST_WDATA)
      |-> addr_q[ADDR_W-1:PAGE_BITS] == $past(addr_q[ADDR_W-1:PAGE_BITS]))
      else $error("page write left the row");

   bit_take_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (st_q == ST_ADDR && scl_rise && !link_busy && !start_ev && !stop_ev)
      |=> shift_q[0] == $past(sda_s))
      else $error("sda not sampled on rising scl");

   wp_hold_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (wp_s && st_q inside {ST_SEL, ST_ADDR} && !start_ev) |=> inhibit_q [*2])
      else $error("protect during address phase lost");

   busy_span_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      write_cycle_start |=> busy_q [*2])
      else $error("write cycle not started");

   sel_ack_c: cover property (@(posedge link_clk) st_q == ST_SEL_ACK && rw_q);
   commit_c: cover property (@(posedge link_clk) trig);
   read_nack_c: cover property (@(posedge link_clk) st_q == ST_RWAIT ##[1:1000] stop_ev);
   wp_block_c: cover property (@(posedge link_clk) st_q == ST_WDATA_ACK && inhibit_q);

endmodule

`default_nettype wire

// *** test/sef_master.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bus master model: push-pull clock, open-drain data
// ----------------------------------------------------------------
module sef_master #(
   parameter int QUARTER = 8
) (
   // timing reference
   input wire logic clock,
   // resolved data line
   input wire logic sda_in,
   // driven pins
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic q();
      repeat (QUARTER) @(posedge clock);
      #1;
   endtask

   // also a repeated start when entered with the clock low
   task automatic start_cond();
      sda_low = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask

   task automatic stop_cond();
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask

   // eight bits msb first, then the acknowledge slot; bit 0 of tx is our ack
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_low = ~tx[i];
         q();
         scl = 1'b1;
         q();
         rx[i] = sda_in;
         q();
         scl = 1'b0;
         q();
      end
   endtask

   // park the clock low without making a bus condition
   task automatic clock_low();
      scl = 1'b0;
      q();
   endtask
endmodule

`default_nettype wire

// *** test/sef_front_end_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module sef_front_end_tb import sef_pkg::*;;
   // arbitrary type value
   localparam logic [3:0] DEV = 4'h6;
   localparam logic [2:0] CS = 3'h5;
   logic clock = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n;
   logic scl;
   logic sda_low;
   logic sda_w;
   logic sda_o;
   logic sda_oe_n;
   logic wp;
   logic mem_wr_en;
   logic mem_rd_en;
   logic write_cycle_start;
   logic write_busy;
   logic [ADDR_W-1:0] mem_wr_addr;
   logic [ADDR_W-1:0] mem_rd_addr;
   logic [7:0] mem_wr_data;
   logic [7:0] mem_rdata;
   logic sda_oe_n2;
   logic [ADDR_W-1:0] mem_wr_addr2;
   logic [7:0] mem_wr_data2;
   logic [18:0] wr_log[$];
   logic [8:0] rx;
   logic a;
   int error_cnt = 0;
   int comparisons = 0;
   int starts = 0;

   always #20 clock = ~clock;
   always #6 link_clk = ~link_clk;
   // pull-up: high unless someone pulls low
   assign sda_w = ~sda_low & (sda_oe_n | sda_o) & sda_oe_n2;

   sef_master #(.QUARTER(8)) sef_master_i (.clock(clock), .sda_in(sda_w), .scl(scl),
      .sda_low(sda_low));

   sef_front_end #(.DEVICE_TYPE(DEV), .HI_ADDR_BITS(0), .WRITE_CYCLE_COUNT(400))
   sef_front_end_i (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .chip_select_strap_0(CS[0]),
      .chip_select_strap_1(CS[1]), .chip_select_strap_2(CS[2]),
      .write_protect_input(wp), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
      .mem_rdata(mem_rdata), .write_cycle_start(write_cycle_start),
      .write_busy(write_busy));

   // second device takes all three select bits as high address bits
   sef_front_end #(.DEVICE_TYPE(4'h3), .HI_ADDR_BITS(3), .WRITE_CYCLE_COUNT(400))
   sef_front_end_hi_i (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl),
      .sda_i(sda_w), .sda_o(), .sda_oe_n(sda_oe_n2), .chip_select_strap_0(1'b0),
      .chip_select_strap_1(1'b0), .chip_select_strap_2(1'b0),
      .write_protect_input(wp), .mem_wr_en(), .mem_wr_addr(mem_wr_addr2),
      .mem_wr_data(mem_wr_data2), .mem_rd_en(), .mem_rd_addr(), .mem_rdata(8'h00),
      .write_cycle_start(), .write_busy());

   // address is registered with the strobe, data is taken the clock after
   assign mem_rdata = mem_rd_addr[7:0] ^ 8'hA5;
   always @(posedge clock) begin
      if (mem_wr_en === 1'b1) wr_log.push_back({mem_wr_addr, mem_wr_data});
      if (write_cycle_start === 1'b1) starts++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic sel(input logic [3:0] t, input logic [2:0] c, input logic rw,
      output logic ack);
      sef_master_i.start_cond();
      sef_master_i.xfer({t, c, rw, 1'b1}, rx);
      ack = ~rx[0];
   endtask

   task automatic wb(input logic [7:0] d, output logic ack);
      sef_master_i.xfer({d, 1'b1}, rx);
      ack = ~rx[0];
   endtask

   task automatic settle();
      repeat (12) @(posedge clock);
      #1;
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end

   initial begin
      rst_n = 1'b0;
      wp = 1'b0; // floating protect modelled as low
      repeat (20) @(posedge clock);
      #1 rst_n = 1'b1;
      settle();
      check("idle release", sda_oe_n, 1);
      sef_master_i.clock_low();
      wb({DEV, CS, 1'b0}, a);
      check("no start ack", a, 0);
      sel(DEV, CS, 1'b0, a);
      check("select ack", a, 1);
      wb(8'h3F, a);
      check("address ack", a, 1);
      wb(8'h11, a);
      check("data0 ack", a, 1);
      wb(8'h22, a);
      check("data1 ack", a, 1);
      sef_master_i.stop_cond();
      settle();
      check("cycle start", 32'(starts), 1);
      check("busy", write_busy, 1);
      check("write count", 32'(wr_log.size()), 2);
      check("write 0", 32'(wr_log[0]), {13'h0, 11'h03F, 8'h11});
      check("write 1", 32'(wr_log[1]), {13'h0, 11'h030, 8'h22});
      sel(DEV, CS, 1'b0, a);
      check("busy poll", a, 0);
      for (int n = 0; n < 20 && !a; n++) begin
         sef_master_i.stop_cond();
         sel(DEV, CS, 1'b0, a);
      end
      check("poll ack", a, 1);
      sef_master_i.stop_cond();
      settle();
      check("no stray cycle", 32'(starts), 1);
      for (int i = 0; i < 4; i++) begin
         sel((i == 3) ? ~DEV : DEV, CS ^ 3'(1 << i), 1'b0, a);
         check("mismatch", a, 0);
         sef_master_i.stop_cond();
      end
      // protect only until the address byte ends
      wp = 1'b1;
      sel(DEV, CS, 1'b0, a);
      check("protect select", a, 1);
      wb(8'h50, a);
      check("protect address", a, 1);
      wp = 1'b0;
      wb(8'h77, a);
      check("protect data", a, 0);
      sef_master_i.stop_cond();
      settle();
      check("protect no write", 32'(wr_log.size()), 2);
      check("protect no cycle", 32'(starts), 1);
      sel(4'h3, 3'h5, 1'b0, a);
      check("high select ack", a, 1);
      wb(8'h12, a);
      wb(8'h44, a);
      sef_master_i.stop_cond();
      settle();
      check("high address", {mem_wr_addr2, mem_wr_data2}, {11'h512, 8'h44});
      wp = 1'b1;
      sel(DEV, CS, 1'b0, a);
      wb(8'h20, a);
      sel(DEV, CS, 1'b1, a);
      check("read select", a, 1);
      sef_master_i.xfer({8'hFF, 1'b0}, rx);
      check("read byte0", rx[8:1], 8'h20 ^ 8'hA5);
      sef_master_i.xfer({8'hFF, 1'b1}, rx);
      check("read byte1", rx[8:1], 8'h21 ^ 8'hA5);
      sef_master_i.stop_cond();
      settle();
      check("standby release", sda_oe_n, 1);
      check("open drain", sda_o, 0);
      wrap_up();
   end
endmodule

`default_nettype wire
